// ===== rtl/sad_pkg.sv
// Constants for the segment address decoder: segments, windows, control fields.
// Assumes a 64-bit core, one clock, synchronous active-high reset.
package sad_pkg;
  localparam int VA_W = 64;
  localparam int PHYS_ADDR_WIDTH = 49;
  localparam int IN_AREA_OFFSET_WIDTH = 49;
  localparam int IO_SEL_BIT = 48;
  localparam int SEG_HI = 63;
  localparam int SEG_LO = 62;
  localparam logic [1:0] SEG_XUSER = 2'h0;
  localparam logic [1:0] SEG_XSUP = 2'h1;
  localparam logic [1:0] SEG_XPHYS = 2'h2;
  localparam logic [1:0] SEG_XKERN = 2'h3;
  localparam logic [1:0] SEL32_KWIN = 2'h0;
  localparam logic [1:0] SEL32_SUP = 2'h2;
  localparam int KWIN_SPAN_BIT = 28;
  localparam logic [15:0] SCR_BASE = 16'h8000;
  localparam logic [15:0] SCR_END = 16'hBFFF;
  localparam logic [15:0] SCR_IO_ADDR = 16'hA200;
  localparam int SCR_HI_LSB = 16;
  localparam int LINE_BYTES = 128;
  localparam int MAX_LINES = 54;
  localparam int WORDS_PER_LINE = 16;
  localparam int SCR_WORDS = MAX_LINES * WORDS_PER_LINE;
  localparam logic [15:0] LM_LIMIT = 16'(SCR_BASE + MAX_LINES * LINE_BYTES);
  localparam int IDX_W = 10;
  localparam int FETCH_OFF_LSB = 54;
  localparam int FETCH_CMD_W = 54;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CTL_UIO = 0;
  localparam int CTL_UMEM = 1;
  localparam int CTL_USCR = 2;
  localparam int CTL_KSCR = 3;
  localparam int CTL_CNT_LSB = 4;
  localparam int CNT_W = 6;
  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_RST = 10'h028;
  localparam int STAT_ERR_BIT = 8;
  localparam int OUTS_W = 8;
  typedef enum logic [1:0] {
    MODE_USER = 2'h0,
    MODE_SUP = 2'h1,
    MODE_KERN = 2'h2
  } sad_mode_t;
endpackage

// ===== rtl/sad_fetch_track.sv
// Outstanding asynchronous fetch counter and barrier wait.
// Assumes each completion answers exactly one earlier launch.
module sad_fetch_track #(
  parameter int CW = 8
) (
  input wire logic clk_i,           // core clock
  input wire logic rst_i,           // sync reset
  input wire logic start_i,         // fetch launched
  input wire logic done_i,          // fetch completed
  input wire logic barrier_i,       // barrier instruction waiting
  output logic [CW-1:0] count_o,    // outstanding fetches
  output logic barrier_wait_o       // hold the barrier
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // Launch never waits; only the barrier is held
  always_comb begin
    cnt_next = cnt_reg;
    if (start_i && !done_i) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (done_i && !start_i && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign count_o = cnt_reg;
  assign barrier_wait_o = barrier_i && (cnt_reg != '0);

  a_barrier_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    barrier_wait_o && !done_i |=> barrier_wait_o || !barrier_i)
    else $error("barrier released with fetches still outstanding");
endmodule

// ===== rtl/sad_scratch.sv
// Scratch line area carved from data cache lines: core port plus fetch result port.
// Assumes the decoder has already checked core indices against the allocation.
module sad_scratch #(
  parameter int DEPTH = 864,
  parameter int AW = 10,
  parameter int DW = 64
) (
  input wire logic clk_i,             // core clock
  input wire logic rst_i,             // sync reset
  input wire logic core_we_i,         // core store
  input wire logic [AW-1:0] core_idx_i, // core word index
  input wire logic [DW-1:0] core_wdata_i, // core store data
  input wire logic fetch_we_i,        // fetch result write
  input wire logic [AW-1:0] fetch_idx_i, // fetch word index
  input wire logic [DW-1:0] fetch_wdata_i, // fetch result
  output logic [DW-1:0] rdata_o       // word at last core index
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;

  always_comb begin
    rdata_next = '0;
    if (32'(core_idx_i) < DEPTH) begin
      rdata_next = mem[core_idx_i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Overrun results land in neighbouring lines; only the array end stops them
  always_ff @(posedge clk_i) begin
    if (core_we_i && 32'(core_idx_i) < DEPTH) begin
      mem[core_idx_i] <= core_wdata_i;
    end
    if (fetch_we_i && 32'(fetch_idx_i) < DEPTH) begin
      mem[fetch_idx_i] <= fetch_wdata_i;
    end
  end

  assign rdata_o = rdata_reg;
endmodule

// ===== rtl/sad_top.sv
// Segment address decoder: classifies each access, gates user rights,
// drives the translation lookup, the scratch area and async fetches.
// Assumes the translation buffer answers combinationally in the request cycle.
//
// Contract
// - Physical window skips translation; low 49 bits are the physical address.
// - Physical bit 48 set selects I/O space, clear selects memory.
// - 32-bit kernel window reaches only the first 256 MB, never I/O.
// - Both 32-bit kernel windows hit the same memory, always cached.
// - I/O accesses are never cached.
// - I/O is reached through translation only by an installed mapping.
// - Mapped access without a matching entry raises a miss; retried later.
// - User physical window access gated by separate I/O and memory enables.
// - Scratch area governed by user enable, kernel enable and line count.
// - User loads and stores to the scratch area need no kernel privilege.
// - Scratch area holds up to 54 lines of 128 bytes each.
// - One fetch launch address; a store there launches a fetch.
// - Launch data carries the scratch offset; the result lands there.
// - Fetches never stall the core; the barrier waits for all outstanding.
// - Illegal or overrunning fetch offset flags an address error; writes may land.
// - Scratch disabled: its range acts as ordinary top kernel mapped area in kernel mode; user and supervisor accesses flag an address error.
// - User 32-bit access to the kernel cached window is refused.
// - 64-bit addresses pick one of four segments from the top two bits.
// - Bits between selector and the 49-bit offset are ignored.
// - 32-bit: top bit zero is user; else next two bits pick segment.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
module sad_top (
  input wire logic clk_i,                   // core clock, 50 MHz
  input wire logic rst_i,                   // sync reset, active high
  input wire logic req_valid_i,             // access request
  input wire logic [63:0] req_addr_i,       // virtual address
  input wire logic req_is32_i,              // 32-bit address space
  input wire logic req_store_i,             // store, else load
  input wire logic [1:0] req_mode_i,        // privilege mode
  input wire logic [63:0] req_wdata_i,      // store data
  output logic tlb_lookup_o,                // translation wanted this cycle
  input wire logic tlb_hit_i,               // matching entry found
  input wire logic [48:0] tlb_pa_i,         // translated address
  output logic resp_valid_o,                // decode result pulse
  output logic [48:0] resp_pa_o,            // physical address
  output logic resp_io_o,                   // targets I/O space
  output logic resp_cached_o,               // may be cached
  output logic resp_scratch_o,              // served by scratch area
  output logic [63:0] resp_rdata_o,         // scratch load data
  output logic tlb_miss_o,                  // miss exception
  output logic trap_o,                      // privilege trap
  output logic addr_err_o,                  // address error
  output logic fetch_start_o,               // async fetch launch pulse
  output logic [53:0] fetch_cmd_o,          // fetch command bits
  output logic [9:0] fetch_off_o,           // scratch word for result
  input wire logic fetch_done_i,            // fetch result valid
  input wire logic [9:0] fetch_done_off_i,  // result scratch word
  input wire logic [63:0] fetch_done_data_i, // result data
  input wire logic barrier_i,               // fetch barrier waiting
  output logic barrier_wait_o,              // hold the barrier
  input wire logic [3:0] reg_addr_i,        // register address
  input wire logic [31:0] reg_wdata_i,      // register write data
  input wire logic reg_wr_i,                // register write strobe
  input wire logic reg_rd_i,                // register read strobe
  output logic [31:0] reg_rdata_o           // read data, cycle after strobe
);
  logic [9:0] ctrl_reg, ctrl_next;
  logic err_reg, err_next;
  logic [31:0] rd_reg, rd_next;
  logic [7:0] outs;
  logic [63:0] ext;
  logic [15:0] lo;
  logic [15:0] off;
  logic [12:0] alloc_bytes;
  logic [9:0] alloc_words, idx, fidx;
  logic is_user, uio, umem, scr_en, in_cvm, mapped;
  logic d_err, d_trap, d_miss, d_io, d_cached, d_scr, d_fetch, d_we;
  logic [48:0] d_pa;
  logic v_reg, io_reg, cached_reg, scr_reg, miss_reg, trap_reg, err_p_reg, fs_reg;
  logic [48:0] pa_reg;
  logic [53:0] cmd_reg;
  logic [9:0] foff_reg;

  assign uio = ctrl_reg[sad_pkg::CTL_UIO];
  assign umem = ctrl_reg[sad_pkg::CTL_UMEM];
  assign alloc_bytes = {ctrl_reg[sad_pkg::CTL_CNT_LSB +: sad_pkg::CNT_W], 7'h00};
  assign alloc_words = {ctrl_reg[sad_pkg::CTL_CNT_LSB +: sad_pkg::CNT_W], 4'h0};

  always_comb begin
    ext = req_is32_i ? {{32{req_addr_i[31]}}, req_addr_i[31:0]} : req_addr_i;
    lo = ext[15:0];
    off = lo - sad_pkg::SCR_BASE;
    idx = off[12:3];
    fidx = req_wdata_i[sad_pkg::FETCH_OFF_LSB +: sad_pkg::IDX_W];
    is_user = (req_mode_i != sad_pkg::MODE_KERN);
    scr_en = is_user ? ctrl_reg[sad_pkg::CTL_USCR] : ctrl_reg[sad_pkg::CTL_KSCR];
    // Ignored bits 61:49 do not take part in the scratch match
    in_cvm = (ext[63:62] == 2'h3) && (&ext[48:sad_pkg::SCR_HI_LSB])
      && (lo >= sad_pkg::SCR_BASE) && (lo <= sad_pkg::SCR_END);
    mapped = 1'b0;
    d_err = 1'b0;
    d_trap = 1'b0;
    d_pa = '0;
    d_scr = 1'b0;
    d_fetch = 1'b0;
    d_we = 1'b0;
    if (in_cvm && scr_en) begin
      if (lo == sad_pkg::SCR_IO_ADDR && req_store_i) begin
        d_fetch = 1'b1;
        d_err = (fidx >= alloc_words);
      end else if (lo < sad_pkg::LM_LIMIT && off[12:0] < alloc_bytes) begin
        d_scr = 1'b1;
        d_we = req_store_i;
      end else begin
        d_err = 1'b1;
      end
    end else if (in_cvm && is_user) begin
      d_err = 1'b1;
    end else if (!req_is32_i) begin
      unique case (ext[sad_pkg::SEG_HI:sad_pkg::SEG_LO])
        sad_pkg::SEG_XUSER: mapped = 1'b1;
        sad_pkg::SEG_XSUP: begin
          d_trap = (req_mode_i == sad_pkg::MODE_USER);
          mapped = !d_trap;
        end
        sad_pkg::SEG_XPHYS: begin
          d_pa = ext[sad_pkg::PHYS_ADDR_WIDTH-1:0];
          d_err = is_user && !(d_pa[sad_pkg::IO_SEL_BIT] ? uio : umem);
        end
        default: begin
          d_trap = is_user;
          mapped = !is_user;
        end
      endcase
    end else if (!ext[31]) begin
      mapped = 1'b1;
    end else begin
      unique case (ext[30:29])
        sad_pkg::SEL32_KWIN, 2'h1: begin
          if (is_user) begin
            d_trap = 1'b1;
          end else if (ext[sad_pkg::KWIN_SPAN_BIT]) begin
            d_err = 1'b1;
          end else begin
            d_pa = {21'h0, ext[sad_pkg::KWIN_SPAN_BIT-1:0]};
          end
        end
        sad_pkg::SEL32_SUP: begin
          d_trap = (req_mode_i == sad_pkg::MODE_USER);
          mapped = !d_trap;
        end
        default: begin
          d_trap = is_user;
          mapped = !is_user;
        end
      endcase
    end
    d_miss = mapped && !tlb_hit_i;
    if (mapped && tlb_hit_i) begin
      d_pa = tlb_pa_i;
    end
    // Refused accesses carry no address; a launch store with a bad offset still starts its fetch
    if (d_err || d_trap) begin
      d_pa = '0;
    end
    d_io = !d_scr && d_pa[sad_pkg::IO_SEL_BIT];
    d_cached = !d_io;
  end

  assign tlb_lookup_o = req_valid_i && mapped;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      v_reg <= 1'b0;
      pa_reg <= '0;
      io_reg <= 1'b0;
      cached_reg <= 1'b0;
      scr_reg <= 1'b0;
      miss_reg <= 1'b0;
      trap_reg <= 1'b0;
      err_p_reg <= 1'b0;
      fs_reg <= 1'b0;
      cmd_reg <= '0;
      foff_reg <= '0;
    end else begin
      v_reg <= req_valid_i;
      pa_reg <= d_pa;
      io_reg <= req_valid_i && d_io;
      cached_reg <= req_valid_i && d_cached;
      scr_reg <= req_valid_i && d_scr;
      miss_reg <= req_valid_i && d_miss;
      trap_reg <= req_valid_i && d_trap;
      err_p_reg <= req_valid_i && d_err;
      fs_reg <= req_valid_i && d_fetch;
      cmd_reg <= req_wdata_i[sad_pkg::FETCH_CMD_W-1:0];
      foff_reg <= fidx;
    end
  end

  sad_scratch #(
    .DEPTH(sad_pkg::SCR_WORDS),
    .AW(sad_pkg::IDX_W),
    .DW(64)
  ) u_scratch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .core_we_i(req_valid_i && d_we),
    .core_idx_i(idx),
    .core_wdata_i(req_wdata_i),
    .fetch_we_i(fetch_done_i),
    .fetch_idx_i(fetch_done_off_i),
    .fetch_wdata_i(fetch_done_data_i),
    .rdata_o(resp_rdata_o)
  );

  sad_fetch_track #(
    .CW(sad_pkg::OUTS_W)
  ) u_track (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(fs_reg),
    .done_i(fetch_done_i),
    .barrier_i(barrier_i),
    .count_o(outs),
    .barrier_wait_o(barrier_wait_o)
  );

  // Register port; error flag set wins over a same-cycle clear
  always_comb begin
    ctrl_next = ctrl_reg;
    err_next = err_reg;
    rd_next = '0;
    if (reg_wr_i && reg_addr_i == sad_pkg::REG_CTRL) begin
      ctrl_next = reg_wdata_i[sad_pkg::CTRL_W-1:0];
    end
    if (reg_wr_i && reg_addr_i == sad_pkg::REG_STAT && reg_wdata_i[sad_pkg::STAT_ERR_BIT]) begin
      err_next = 1'b0;
    end
    if (err_p_reg) begin
      err_next = 1'b1;
    end
    if (reg_rd_i && reg_addr_i == sad_pkg::REG_CTRL) begin
      rd_next = {22'h0, ctrl_reg};
    end else if (reg_rd_i && reg_addr_i == sad_pkg::REG_STAT) begin
      rd_next = {23'h0, err_reg, outs};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= sad_pkg::CTRL_RST;
      err_reg <= 1'b0;
      rd_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      err_reg <= err_next;
      rd_reg <= rd_next;
    end
  end

  assign reg_rdata_o = rd_reg;
  assign resp_valid_o = v_reg;
  assign resp_pa_o = pa_reg;
  assign resp_io_o = io_reg;
  assign resp_cached_o = cached_reg;
  assign resp_scratch_o = scr_reg;
  assign tlb_miss_o = miss_reg;
  assign trap_o = trap_reg;
  assign addr_err_o = err_p_reg;
  assign fetch_start_o = fs_reg;
  assign fetch_cmd_o = cmd_reg;
  assign fetch_off_o = foff_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_kern_phys;
    req_valid_i && !req_is32_i && req_mode_i == sad_pkg::MODE_KERN && req_addr_i[63:62] == 2'h2;
  endsequence

  a_phys_strip: assert property (s_kern_phys |=>
    resp_pa_o == $past(req_addr_i[48:0]) && !tlb_miss_o && !addr_err_o)
    else $error("physical window address not stripped");
  a_io_split: assert property (s_kern_phys |=> resp_io_o == $past(req_addr_i[48]))
    else $error("I/O split does not follow bit 48");
  a_kwin_range: assert property (req_valid_i && req_is32_i
    && req_mode_i == sad_pkg::MODE_KERN && req_addr_i[31:30] == 2'h2
    |=> !resp_io_o && resp_pa_o[48:28] == 21'h0)
    else $error("kernel window left the low region");
  a_mem_cached: assert property (resp_valid_o && !resp_io_o && !resp_scratch_o
    && !tlb_miss_o && !trap_o && !addr_err_o |-> resp_cached_o)
    else $error("memory access not cached");
  a_io_uncached: assert property (resp_io_o |-> !resp_cached_o)
    else $error("I/O access marked cacheable");
  a_miss_flag: assert property (tlb_lookup_o |=> tlb_miss_o != $past(tlb_hit_i))
    else $error("missing translation not flagged");
  a_user_io_gate: assert property (req_valid_i && !req_is32_i
    && req_mode_i == sad_pkg::MODE_USER && req_addr_i[63:62] == 2'h2
    && req_addr_i[48] && !uio |=> addr_err_o && !fetch_start_o)
    else $error("user physical I/O not refused");
  a_kwin_user_trap: assert property (req_valid_i && req_is32_i
    && req_mode_i == sad_pkg::MODE_USER && req_addr_i[31:30] == 2'h2 |=> trap_o)
    else $error("user kernel window access not trapped");
  a_fetch_launch: assert property (req_valid_i && req_store_i && in_cvm && scr_en
    && lo == sad_pkg::SCR_IO_ADDR |=> fetch_start_o && fetch_off_o == $past(fidx))
    else $error("store to launch address did not start fetch");
endmodule

// ===== tb/sad_far_model.sv
// Far-side model: translation buffer with two installed pages and an async fetch responder.
// Assumes the decoder launches fetches as single-cycle pulses; hold_i stalls completions.
module sad_far_model (
  input wire logic clk_i,             // core clock
  input wire logic rst_i,             // sync reset
  input wire logic lookup_i,          // translation wanted
  input wire logic [63:0] addr_i,     // virtual address
  output logic hit_o,                 // entry found
  output logic [48:0] pa_o,           // translated address
  input wire logic start_i,           // fetch launched
  input wire logic [9:0] off_i,       // result scratch word
  input wire logic [53:0] cmd_i,      // fetch command
  input wire logic hold_i,            // stall completions
  output logic done_o,                // result valid
  output logic [9:0] done_off_o,      // result scratch word
  output logic [63:0] done_data_o     // result data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] q[$];
  logic [63:0] last;
  // Only user pages 0x0000 (memory) and 0x1000 (I/O) are installed
  always_comb begin
    hit_o = lookup_i && (addr_i[63:13] == 51'h0);
    pa_o = hit_o ? {addr_i[12], 36'h0, addr_i[11:0]} : ~addr_i[48:0];
  end
  initial begin
    done_o = 1'b0;
    done_off_o = 10'h000;
    done_data_o = 64'h0;
  end
  // Idle result lines toggle so a stale value is never mistaken for a result
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    done_off_o <= ~done_off_o;
    done_data_o <= ~done_data_o;
    if (rst_i) begin
      q.delete();
    end else begin
      if (start_i) q.push_back({off_i, cmd_i});
      if (!hold_i && q.size() > 0) begin
        last = q.pop_front();
        done_o <= 1'b1;
        done_off_o <= last[63:54];
        done_data_o <= {10'h000, last[53:0]};
      end
    end
  end
endmodule

// ===== tb/segment_address_decoder_tb_top.sv
// Self-checking bench for the segment address decoder: table of accesses, then
// register, fetch, barrier and reset cases. Assumes the far-side model alongside.
module segment_address_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [9:0] ctl;
    logic [63:0] addr;
    logic is32;
    logic st;
    logic [1:0] mode;
    logic [63:0] wd;
    logic [48:0] pa;
    logic [6:0] fl;
    logic [63:0] rd;
  } sad_row_t;
  localparam logic [1:0] U = sad_pkg::MODE_USER;
  localparam logic [1:0] S = sad_pkg::MODE_SUP;
  localparam logic [1:0] K = sad_pkg::MODE_KERN;
  localparam logic [63:0] SW = 64'h0123_4567_89AB_CDEF;
  // Flags: lookup, io, cached, scratch, miss, trap, error
  localparam sad_row_t ROWS [28] = '{
    '{10'h028, 64'h8000_0000_0000_1000, 1'b0, 1'b0, K, 64'h0, 49'h1000, 7'h10, 64'h0},
    '{10'h028, 64'h8001_0000_0000_0040, 1'b0, 1'b0, K, 64'h0, 49'h1_0000_0000_0040, 7'h20, 64'h0},
    '{10'h028, 64'h9FFE_0000_0000_2000, 1'b0, 1'b0, K, 64'h0, 49'h2000, 7'h10, 64'h0},
    '{10'h028, 64'h8000_0000_0000_1000, 1'b0, 1'b0, U, 64'h0, 49'h0, 7'h01, 64'h0},
    '{10'h028, 64'hC000_0000_0000_0000, 1'b0, 1'b0, U, 64'h0, 49'h0, 7'h02, 64'h0},
    '{10'h028, 64'h8000_0000_0000_1000, 1'b0, 1'b0, S, 64'h0, 49'h0, 7'h01, 64'h0},
    '{10'h028, 64'h4000_0000_0000_0010, 1'b0, 1'b0, S, 64'h0, 49'h0, 7'h44, 64'h0},
    '{10'h028, 64'h4000_0000_0000_0010, 1'b0, 1'b0, U, 64'h0, 49'h0, 7'h02, 64'h0},
    '{10'h028, 64'h0000_0000_C000_0000, 1'b1, 1'b0, S, 64'h0, 49'h0, 7'h44, 64'h0},
    '{10'h028, 64'h0000_0000_0000_0010, 1'b0, 1'b0, U, 64'h0, 49'h10, 7'h50, 64'h0},
    '{10'h028, 64'h0000_0000_0000_1008, 1'b0, 1'b0, U, 64'h0, 49'h1_0000_0000_0008, 7'h60, 64'h0},
    '{10'h028, 64'h0000_0000_0010_0000, 1'b0, 1'b0, U, 64'h0, 49'h0, 7'h44, 64'h0},
    '{10'h028, 64'h0000_0000_8000_1000, 1'b1, 1'b0, K, 64'h0, 49'h1000, 7'h10, 64'h0},
    '{10'h028, 64'h0000_0000_A000_1000, 1'b1, 1'b0, K, 64'h0, 49'h1000, 7'h10, 64'h0},
    '{10'h028, 64'h0000_0000_9000_0000, 1'b1, 1'b0, K, 64'h0, 49'h0, 7'h01, 64'h0},
    '{10'h028, 64'h0000_0000_8000_1000, 1'b1, 1'b0, U, 64'h0, 49'h0, 7'h02, 64'h0},
    '{10'h028, 64'h0000_0000_E000_0000, 1'b1, 1'b0, K, 64'h0, 49'h0, 7'h44, 64'h0},
    '{10'h028, 64'hFFFF_FFFF_FFFF_8008, 1'b0, 1'b1, K, SW, 49'h0, 7'h18, 64'h0},
    '{10'h028, 64'hFFFF_FFFF_FFFF_8008, 1'b0, 1'b0, K, 64'h0, 49'h0, 7'h18, SW},
    '{10'h028, 64'hFFFF_FFFF_FFFF_8100, 1'b0, 1'b0, K, 64'h0, 49'h0, 7'h01, 64'h0},
    '{10'h028, 64'hFFFF_FFFF_FFFF_A200, 1'b0, 1'b0, K, 64'h0, 49'h0, 7'h01, 64'h0},
    '{10'h028, 64'hFFFF_FFFF_FFFF_8008, 1'b0, 1'b0, U, 64'h0, 49'h0, 7'h01, 64'h0},
    '{10'h36E, 64'h8000_0000_0000_3000, 1'b0, 1'b0, U, 64'h0, 49'h3000, 7'h10, 64'h0},
    '{10'h36E, 64'h8001_0000_0000_0000, 1'b0, 1'b0, U, 64'h0, 49'h0, 7'h01, 64'h0},
    '{10'h36E, 64'hFFFF_FFFF_FFFF_9AF8, 1'b0, 1'b1, U, 64'h5A5A, 49'h0, 7'h18, 64'h0},
    '{10'h36E, 64'hFFFF_FFFF_FFFF_9AF8, 1'b0, 1'b0, U, 64'h0, 49'h0, 7'h18, 64'h5A5A},
    '{10'h36E, 64'hFFFF_FFFF_FFFF_9B00, 1'b0, 1'b0, U, 64'h0, 49'h0, 7'h01, 64'h0},
    '{10'h020, 64'hFFFF_FFFF_FFFF_8008, 1'b0, 1'b0, K, 64'h0, 49'h0, 7'h44, 64'h0}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_is32 = 1'b0, req_store = 1'b0;
  logic [63:0] req_addr = 64'h0, req_wdata = 64'h0;
  logic [1:0] req_mode = 2'h0;
  logic barrier = 1'b0, hold = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic tlb_lookup, tlb_hit, resp_valid, resp_io, resp_cached, resp_scratch, lk;
  logic tlb_miss, trap, addr_err, fetch_start, fetch_done, barrier_wait;
  logic [48:0] tlb_pa, resp_pa;
  logic [63:0] resp_rdata, fetch_done_data;
  logic [53:0] fetch_cmd;
  logic [9:0] fetch_off, fetch_done_off;
  int mismatches = 0;
  int checks_done = 0;
  sad_row_t r;
  always #10 clk = ~clk;
  sad_top i_sad_top (.clk_i(clk), .rst_i(rst), .req_valid_i(req_valid), .req_addr_i(req_addr),
    .req_is32_i(req_is32), .req_store_i(req_store), .req_mode_i(req_mode),
    .req_wdata_i(req_wdata), .tlb_lookup_o(tlb_lookup), .tlb_hit_i(tlb_hit), .tlb_pa_i(tlb_pa),
    .resp_valid_o(resp_valid), .resp_pa_o(resp_pa), .resp_io_o(resp_io),
    .resp_cached_o(resp_cached), .resp_scratch_o(resp_scratch), .resp_rdata_o(resp_rdata),
    .tlb_miss_o(tlb_miss), .trap_o(trap), .addr_err_o(addr_err), .fetch_start_o(fetch_start),
    .fetch_cmd_o(fetch_cmd), .fetch_off_o(fetch_off), .fetch_done_i(fetch_done),
    .fetch_done_off_i(fetch_done_off), .fetch_done_data_i(fetch_done_data),
    .barrier_i(barrier), .barrier_wait_o(barrier_wait), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
  sad_far_model i_sad_far_model (.clk_i(clk), .rst_i(rst), .lookup_i(tlb_lookup),
    .addr_i(req_addr), .hit_o(tlb_hit), .pa_o(tlb_pa), .start_i(fetch_start),
    .off_i(fetch_off), .cmd_i(fetch_cmd), .hold_i(hold), .done_o(fetch_done),
    .done_off_o(fetch_done_off), .done_data_o(fetch_done_data));
  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_rd_t(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Lookup is sampled inside the request cycle, the answer one edge later
  task automatic access(input sad_row_t x);
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= x.addr;
    req_is32 <= x.is32;
    req_store <= x.st;
    req_mode <= x.mode;
    req_wdata <= x.wd;
    #1 lk = tlb_lookup;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
  endtask
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk(64'({resp_valid, fetch_start, barrier_wait, reg_rdata}), 64'h0);
    reg_rd_t(sad_pkg::REG_CTRL);
    chk(64'(rv), 64'h028);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      reg_wr_t(sad_pkg::REG_CTRL, {22'h0, r.ctl});
      access(r);
      chk(64'(resp_valid), 64'h1);
      chk(64'({resp_io, resp_scratch, tlb_miss, trap, addr_err}), 64'({r.fl[5], r.fl[3:0]}));
      if (r.fl[2:0] == 3'h0) chk(64'(resp_cached), 64'(r.fl[4]));
      if (!r.fl[2]) chk(64'(resp_pa), 64'(r.pa));
      if (r.fl[1:0] == 2'h0) chk(64'(lk), 64'(r.fl[6]));
      if (r.fl[3] && !r.st) chk(resp_rdata, r.rd);
    end
    reg_wr_t(sad_pkg::REG_CTRL, 32'h028);
    reg_wr_t(sad_pkg::REG_STAT, 32'h100);
    @(posedge clk);
    hold <= 1'b1;
    r = '{10'h028, 64'hFFFF_FFFF_FFFF_A200, 1'b0, 1'b1, K, {10'h005, 54'hABC}, 49'h0, 7'h0, 64'h0};
    access(r);
    chk(64'({fetch_start, addr_err, fetch_off}), 64'({2'h2, 10'h005}));
    chk(64'(fetch_cmd), 64'h0ABC);
    r.wd = {10'h028, 54'hDEF};
    access(r);
    chk(64'({fetch_start, addr_err, fetch_off}), 64'({2'h3, 10'h028}));
    @(posedge clk);
    barrier <= 1'b1;
    access(ROWS[0]);
    chk(64'({resp_valid, barrier_wait}), 64'h3);
    reg_rd_t(sad_pkg::REG_STAT);
    chk(64'(rv), 64'h102);
    @(posedge clk);
    hold <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (!barrier_wait) break;
    end
    chk(64'(barrier_wait), 64'h0);
    barrier <= 1'b0;
    r = '{10'h028, 64'hFFFF_FFFF_FFFF_8028, 1'b0, 1'b0, K, 64'h0, 49'h0, 7'h08, 64'h0};
    access(r);
    chk(resp_rdata, {10'h000, 54'hABC});
    reg_rd_t(4'h8);
    chk(64'(rv), 64'h0);
    reg_wr_t(sad_pkg::REG_STAT, 32'h100);
    reg_rd_t(sad_pkg::REG_STAT);
    chk(64'(rv), 64'h0);
    reg_wr_t(sad_pkg::REG_CTRL, 32'h000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_rd_t(sad_pkg::REG_CTRL);
    chk(64'(rv), 64'h028);
    end_of_test();
  end
endmodule
